// ===== hw/asr_defines.svh
// What this block does
// - Enabled clock edge shifts all bits one stage deeper, input bit enters stage zero.
// - Sixteen one-bit stages, chosen by a four-bit address, zero is newest.
// - Address zero shows the bit just shifted in, right after the shifting edge.
// - Reading is combinational; an address change shows the new stage at once.
// - Stage k holds the bit shifted in k shifts before the latest one.
// - Last stage drives the cascade output; first bit appears after sixteen shifts.
// - Cascade output changes only on shifting edges; routable to chain or bypass.
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

`define ASR_DEPTH      16
`define ASR_ADDR_W     4
`define ASR_CHAIN_RST  16'h0000
`define ASR_BIT_RST    1'b0
`define ASR_FIRST_TAP  4'h0
`define ASR_AGE_TAP    4'h2
`define ASR_READY_RST  1'b1

`endif

// ===== hw/asr_pkg.sv
`default_nettype none
`include "asr_defines.svh"

package asr_pkg;
	typedef logic [`ASR_ADDR_W-1:0] stage_addr_t;
	typedef logic [`ASR_DEPTH-1:0]  chain_t;
endpackage

`default_nettype wire

// ===== hw/addressable_shift_chain.sv
`default_nettype none
`include "asr_defines.svh"

module addressable_shift_chain #(
	parameter int DEPTH = `ASR_DEPTH
) (
	input  wire logic                 mclk,
	input  wire logic                 arst_n,
	input  wire logic                 ce,
	input  wire logic                 enable_pin_shared,
	input  wire logic                 serial_bit_in,
	input  wire asr_pkg::stage_addr_t stage_addr,
	input  wire logic                 bypass_route_sel,
	output logic                      addr_bit_out,
	output logic                      cascade_tap_out,
	output logic                      slice_bypass_out,
	output logic                      shift_ready,
	output logic                      spill_bit,
	output logic                      spill_valid,
	input  wire logic                 spill_ready
);

	// ==========================================================
	// Shift chain
	asr_pkg::chain_t chain_q;
	asr_pkg::chain_t chain_d;
	logic            ready_q;
	wire logic       shift_fire;
	wire logic       displaced_bit;

	// Enable is ignored while the spill buffer has no room
	assign shift_fire    = ce & enable_pin_shared & ready_q;
	assign displaced_bit = chain_q[DEPTH-1];

	assign chain_d = shift_fire ? {chain_q[DEPTH-2:0], serial_bit_in} : chain_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			chain_q <= `ASR_CHAIN_RST;
		end else begin
			chain_q <= chain_d;
		end
	end

	// ==========================================================
	// Addressable read
	// Pure mux of flops: the rules demand a clockless read path
	assign addr_bit_out = chain_q[stage_addr];

	// ==========================================================
	// Cascade and bypass taps
	logic bypass_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bypass_q <= `ASR_BIT_RST;
		end else if (shift_fire) begin
			bypass_q <= bypass_route_sel ? chain_d[DEPTH-1] : `ASR_BIT_RST;
		end
	end

	assign cascade_tap_out  = chain_q[DEPTH-1];
	assign slice_bypass_out = bypass_q;

	// ==========================================================
	// Two-entry spill buffer for bits leaving the last stage
	// Head is always the older entry, so spill_bit is a flop
	logic head_q;
	logic head_v_q;
	logic tail_q;
	logic tail_v_q;
	logic head_d;
	logic head_v_d;
	logic tail_d;
	logic tail_v_d;
	wire logic pop;

	assign pop = head_v_q & spill_ready;

	always_comb begin
		head_d   = head_q;
		head_v_d = head_v_q;
		tail_d   = tail_q;
		tail_v_d = tail_v_q;
		if (pop) begin
			head_d   = tail_q;
			head_v_d = tail_v_q;
			tail_v_d = 1'b0;
		end
		if (shift_fire) begin
			if (!head_v_d) begin
				head_d   = displaced_bit;
				head_v_d = 1'b1;
			end else begin
				tail_d   = displaced_bit;
				tail_v_d = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			head_q   <= `ASR_BIT_RST;
			head_v_q <= `ASR_BIT_RST;
			tail_q   <= `ASR_BIT_RST;
			tail_v_q <= `ASR_BIT_RST;
			ready_q  <= `ASR_READY_RST;
		end else if (ce) begin
			head_q   <= head_d;
			head_v_q <= head_v_d;
			tail_q   <= tail_d;
			tail_v_q <= tail_v_d;
			ready_q  <= !tail_v_d;
		end
	end

	assign spill_bit   = head_q;
	assign spill_valid = head_v_q;
	assign shift_ready = ready_q;

	// ==========================================================
	// Checks
	// Copy of the chain one ce-enabled edge back, used only by the read-path check
	asr_pkg::chain_t chain_prev_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			chain_prev_q <= `ASR_CHAIN_RST;
		end else if (ce) begin
			chain_prev_q <= chain_q;
		end
	end

	property p_shift_in;
		@(posedge mclk) disable iff (!arst_n)
		shift_fire |=> chain_q[0] == $past(serial_bit_in);
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("new bit not in stage zero");

	property p_shift_deeper;
		@(posedge mclk) disable iff (!arst_n)
		shift_fire |=> chain_q[DEPTH-1:1] == $past(chain_q[DEPTH-2:0]);
	endproperty
	a_shift_deeper: assert property (p_shift_deeper) else $error("chain did not move");

	property p_addr_zero;
		@(posedge mclk) disable iff (!arst_n)
		(shift_fire && stage_addr == `ASR_FIRST_TAP) ##1 (stage_addr == `ASR_FIRST_TAP)
			|-> addr_bit_out == $past(serial_bit_in);
	endproperty
	a_addr_zero: assert property (p_addr_zero) else $error("address zero stale");

	property p_comb_read;
		@(posedge mclk) disable iff (!arst_n)
		($changed(stage_addr) && $past(ce) && !$past(shift_fire))
			|-> addr_bit_out == chain_prev_q[stage_addr];
	endproperty
	a_comb_read: assert property (p_comb_read) else $error("read not immediate");

	property p_age;
		@(posedge mclk) disable iff (!arst_n)
		shift_fire ##1 shift_fire ##1 shift_fire ##1 (stage_addr == `ASR_AGE_TAP)
			|-> addr_bit_out == $past(serial_bit_in, 3);
	endproperty
	a_age: assert property (p_age) else $error("stage two holds wrong bit");

	// Starts only on sixteen back-to-back shifts
	property p_cascade;
		@(posedge mclk) disable iff (!arst_n)
		shift_fire [*8] ##1 shift_fire [*8]
			|=> cascade_tap_out == $past(serial_bit_in, 16);
	endproperty
	a_cascade: assert property (p_cascade) else $error("cascade not after 16 shifts");

	property p_cascade_still;
		@(posedge mclk) disable iff (!arst_n)
		!shift_fire |=> $stable(cascade_tap_out) && $stable(slice_bypass_out);
	endproperty
	a_cascade_still: assert property (p_cascade_still) else $error("tap moved idle");

	property p_bypass_route;
		@(posedge mclk) disable iff (!arst_n)
		(shift_fire && bypass_route_sel) |=> slice_bypass_out == cascade_tap_out;
	endproperty
	a_bypass_route: assert property (p_bypass_route) else $error("bypass misrouted");

	property p_hold;
		@(posedge mclk) disable iff (!arst_n)
		!(ce && enable_pin_shared) |=> $stable(chain_q);
	endproperty
	a_hold: assert property (p_hold) else $error("chain changed while disabled");

	property p_spill;
		@(posedge mclk) disable iff (!arst_n)
		(shift_fire && !head_v_q) |=> spill_valid && spill_bit == $past(displaced_bit);
	endproperty
	a_spill: assert property (p_spill) else $error("displaced bit lost");

	// Ready is a flop, so the tail filling must drop it one cycle early
	property p_ready_drop;
		@(posedge mclk) disable iff (!arst_n)
		(shift_fire && head_v_q && !spill_ready) |=> !shift_ready;
	endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("ready stayed high when full");

	// Back-pressure drops the bit: enable alone does not shift
	property p_refuse;
		@(posedge mclk) disable iff (!arst_n)
		(enable_pin_shared && !shift_ready) |=> $stable(chain_q);
	endproperty
	a_refuse: assert property (p_refuse) else $error("shift taken while not ready");

	property p_spill_hold;
		@(posedge mclk) disable iff (!arst_n)
		(spill_valid && !spill_ready) |=> spill_valid && $stable(spill_bit);
	endproperty
	a_spill_hold: assert property (p_spill_hold) else $error("spill bit moved before pop");

	property p_freeze;
		@(posedge mclk) disable iff (!arst_n)
		!ce |=> $stable(spill_valid) && $stable(shift_ready);
	endproperty
	a_freeze: assert property (p_freeze) else $error("buffer moved while frozen");

endmodule

`default_nettype wire

// ===== test/spill_sink.sv
`default_nettype none
// ==========
// Receiver of pushed-out bits, stalls on command
module spill_sink (
	input  wire logic stall,
	output logic      spill_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	assign spill_ready = ~stall;
endmodule
`default_nettype wire

// ===== test/addressable_shift_chain_bench.sv
`default_nettype none
module addressable_shift_chain_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, arst_n = 0, ce = 1, en = 0, din = 0, route = 1, stall = 0;
	asr_pkg::stage_addr_t addr = 4'h0;
	wire logic aout, casc, byp, rdy, sbit, svld, srdy;
	logic [15:0] m = 16'h0000;
	int n_errors = 0, total_checks = 0, cyc = 0;
	addressable_shift_chain addressable_shift_chain_inst (.mclk(mclk), .arst_n(arst_n),
		.ce(ce), .enable_pin_shared(en), .serial_bit_in(din), .stage_addr(addr),
		.bypass_route_sel(route), .addr_bit_out(aout), .cascade_tap_out(casc),
		.slice_bypass_out(byp), .shift_ready(rdy), .spill_bit(sbit), .spill_valid(svld),
		.spill_ready(srdy));
	spill_sink spill_sink_inst (.stall(stall), .spill_ready(srdy));
	initial forever #25 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			end_sim();
		end
	end
	// ==========
	// Shared helpers
	task automatic chk(input logic a, input logic e);
		total_checks++;
		if (a !== e) begin
			n_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, a, e);
		end
	endtask
	// Starts and ends on a falling edge; model follows only shifts the block takes.
	// One idle edge at the end, so back-to-back calls never set en twice at once.
	task automatic shift_run(input logic [15:0] bits, input int n);
		logic r;
		en = 1;
		for (int i = 0; i < n; i++) begin
			din = bits[i];
			r = rdy & ce;
			@(negedge mclk);
			if (r) m = {m[14:0], bits[i]};
		end
		en = 0;
		@(negedge mclk);
	endtask
	// Address moves on a falling edge and is read before any rising edge
	task automatic probe(input logic [3:0] k, input logic e);
		addr = k;
		#1;
		chk(aout, e);
		@(negedge mclk);
	endtask
	task automatic read_all();
		for (int k = 0; k < 16; k++) probe(k[3:0], m[k]);
		addr = 4'h0;
	endtask
	// ==========
	// Scenarios
	task automatic t_order();
		read_all();
		shift_run(16'h0001, 1);
		chk(aout, 1'b1);
		shift_run(16'h0000, 1);
		chk(aout, 1'b0);
		probe(4'h1, 1'b1);
		shift_run(16'h0000, 1);
		probe(4'h2, 1'b1);
		probe(4'h0, 1'b0);
		$display("done order");
	endtask
	task automatic t_cascade();
		addr = 4'h2;
		shift_run(16'h0000, 12);
		chk(casc, 1'b0);
		chk(aout, m[2]);
		shift_run(16'h0000, 1);
		chk(casc, 1'b1);
		chk(byp, 1'b1);
		route = 0;
		@(negedge mclk);
		chk(byp, 1'b1);
		shift_run(16'h3c96, 16);
		chk(casc, 1'b0);
		chk(byp, 1'b0);
		shift_run(16'h0001, 1);
		chk(casc, 1'b1);
		chk(byp, 1'b0);
		route = 1;
		shift_run(16'h0000, 1);
		chk(casc, m[15]);
		chk(byp, 1'b1);
		$display("done cascade");
	endtask
	task automatic t_hold();
		ce = 0;
		shift_run(16'h0003, 2);
		ce = 1;
		read_all();
		$display("done hold");
	endtask
	task automatic t_fill();
		logic [1:0] out;
		out = m[15:14];
		stall = 1;
		shift_run(16'h000f, 4);
		chk(rdy, 1'b0);
		chk(svld, 1'b1);
		chk(sbit, out[1]);
		stall = 0;
		@(negedge mclk);
		chk(rdy, 1'b1);
		chk(svld, 1'b1);
		chk(sbit, out[0]);
		@(negedge mclk);
		chk(svld, 1'b0);
		read_all();
		$display("done fill");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge mclk);
		arst_n = 1;
		t_order();
		t_cascade();
		t_hold();
		t_fill();
		end_sim();
	end
endmodule
`default_nettype wire
